// ---- src/ipm_clk_gen.sv ----
// bus clock, pci clock and memory clock generation for the pad mux
// assumes clk is the host clock and the strap latches hold after reset
`timescale 1ns/1ps
module ipm_clk_gen
    import ipm_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pciDiv3,
    input  wire logic memSync,
    input  wire logic memAsyncClk,
    output logic      isaBusClock,
    output logic      pciClockOut,
    output logic      memoryClockOut
);

    typedef struct packed {
        logic [3:0] isaCnt;
        logic       isaClk;
        logic [1:0] pciCnt;
        logic       pciClk;
    } ipm_clk_state_type;

    ipm_clk_state_type stR;
    ipm_clk_state_type stN;
    logic [1:0]        pciLast;

    // next clock state
    always_comb begin
        stN = stR;
        pciLast = pciDiv3 ? PCI_DIV3_LAST : PCI_DIV2_LAST;
        if (!rst_n) begin
            stN = '0;
        end else begin
            if (stR.isaCnt == ISA_HALF_LAST) begin
                stN.isaCnt = '0;
                stN.isaClk = ~stR.isaClk;
            end else begin
                stN.isaCnt = stR.isaCnt + 4'h1;
            end
            // host divided by two or three
            if (stR.pciCnt == pciLast) begin
                stN.pciCnt = '0;
            end else begin
                stN.pciCnt = stR.pciCnt + 2'h1;
            end
            stN.pciClk = (stN.pciCnt == 2'h0);
        end
    end

    always_ff @(posedge clk) begin
        stR <= stN;
    end

    assign isaBusClock = stR.isaClk;
    assign pciClockOut = stR.pciClk;

    // memory clock source select
    // plain clock mux: safe only because the strap never moves in use
    assign memoryClockOut = memSync ? clk : memAsyncClk;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_isa_high;
        isaBusClock [*8];
    endsequence

    sequence s_isa_low;
        !isaBusClock [*8];
    endsequence

    a_isa_bus_clock_reset: assert property (
        disable iff (1'b0) !rst_n |=> !isaBusClock)
        else $error("bus clock not low during reset");

    a_isa_bus_clock_high: assert property (
        $rose(isaBusClock) |-> ##1 s_isa_high ##1 !isaBusClock)
        else $error("bus clock high phase wrong length");

    a_isa_bus_clock_low: assert property (
        $fell(isaBusClock) |-> ##1 s_isa_low ##1 isaBusClock)
        else $error("bus clock low phase wrong length");

    a_pci_div_two: assert property (
        !pciDiv3 && $rose(pciClockOut) |=> !pciClockOut ##1 pciClockOut)
        else $error("pci clock not host divided by two");

    a_pci_div_three: assert property (
        pciDiv3 && $rose(pciClockOut)
            |=> !pciClockOut ##1 !pciClockOut ##1 pciClockOut)
        else $error("pci clock not host divided by three");

endmodule

// ---- src/ipm_pin_mux.sv ----
// shared-pad mux: strap-chosen bus, time-shared with ide, plus clocks
// assumes controllers drive ipm_src_drive_type bundles and that the board
// gates the ide chip selects with the bus output enable pad
//
// Behaviour
// - bus choice taken from straps only
// - ide and bus share pads at run time, except on local bus
// - enable pad high for ide, low bus; select bit 3 on local bus
// - address bit 2 pad zero for cards
// - address bits 1:0 carry upper addresses
// - chip select pads carry upper addresses
// - data 15:12 carry selects or float
// - data 11:0 carry bus address 19:8
// - ready pad routed per mode
// - data pads carry strapped bus data
// - rtc strobe and clock pads per mode
// - low address pads become selects, ready
// - write and io16 pads become byte enables
// - master and mem16 pads become strobes
// - dma acknowledge fixed four for cards
// - io strobes become address 12, 13
// - aen and bhe become wait, oe, address
// - dma request pads become card enables
// - address 24:22 pads float on isa
// - selects 7:4 float on isa
// - bus clock low in reset, 7MHz after
// - pci clock is host over two/three
// - memory clock async or host rate
`timescale 1ns/1ps
module ipm_pin_mux
    import ipm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [1:0]        strapMode,
    input  wire logic              strapPciDiv3,
    input  wire logic              strapMemSync,
    input  wire logic              devClk24,
    input  wire logic              memAsyncClk,
    input  wire ipm_ide_drive_type ideDrv,
    input  wire ipm_src_drive_type isaDrv,
    input  wire ipm_src_drive_type pcmDrv,
    input  wire ipm_src_drive_type lbDrv,
    input  wire logic              ideReq,
    input  wire logic              ideBusy,
    input  wire logic              busReq,
    input  wire logic              busBusy,
    input  wire logic              padRdyIn,
    input  wire logic [W_BUS-1:0]  padBusIn,
    output logic                   ideGrant,
    output logic                   busGrant,
    output logic [W_IDE-1:0]       padIdeOut,
    output logic [W_IDE-1:0]       padIdeOe,
    output logic [W_BUS-1:0]       padBusOut,
    output logic [W_BUS-1:0]       padBusOe,
    output logic                   padIsaOe,
    output logic                   ideReady,
    output logic                   isaChRdy,
    output logic                   lbDataReady,
    output ipm_mode_type           activeMode,
    output logic                   isaBusClock,
    output logic                   pciClockOut,
    output logic                   memoryClockOut
);

    typedef struct packed {
        ipm_mode_type     mode;
        logic             pciDiv3;
        logic             memSync;
        ipm_arb_type      arb;
        logic             ideOwn;
        logic [W_IDE-1:0] ideOut;
        logic [W_IDE-1:0] ideOe;
        logic [W_BUS-1:0] busOut;
        logic [W_BUS-1:0] busOe;
        logic             isa_bus_output_enable;
        logic             clkPass;
    } ipm_mux_state_type;

    ipm_mux_state_type stR;
    ipm_mux_state_type stN;
    ipm_src_drive_type src;
    ipm_mode_type      strapDec;
    logic              ownNxt;

    // strap decode; the unused code falls back to isa
    always_comb begin
        unique case (strapMode)
            STRAP_PCM: strapDec = MODE_PCM;
            STRAP_LB:  strapDec = MODE_LB;
            default:   strapDec = MODE_ISA;
        endcase
    end

    // next state: arbiter, source pick, per-mode pad overrides
    always_comb begin
        stN = stR;
        src = isaDrv;
        ownNxt = 1'b0;
        if (!rst_n) begin
            // straps caught only while in reset
            stN.mode = strapDec;
            stN.pciDiv3 = strapPciDiv3;
            stN.memSync = strapMemSync;
            stN.arb = ARB_BUS;
            stN.ideOwn = 1'b0;
            stN.ideOut = '0;
            stN.ideOe = '0;
            stN.busOut = '0;
            stN.busOe = '0;
            stN.isa_bus_output_enable = RST_ISA_BUS_OUTPUT_ENABLE;
            stN.clkPass = 1'b0;
        end else begin
            unique case (stR.arb)
                ARB_BUS: begin
                    if (ideReq && !busBusy) begin
                        stN.arb = ARB_IDE;
                    end
                end
                ARB_IDE: begin
                    if (!ideBusy && (busReq || !ideReq)) begin
                        stN.arb = ARB_BUS;
                    end
                end
            endcase
            // local bus never uses the ide group, so ide keeps it
            ownNxt = (stR.mode == MODE_LB) || (stN.arb == ARB_IDE);
            stN.ideOwn = ownNxt;

            // io strobes follow the strapped bus
            unique case (stR.mode)
                MODE_ISA: src = isaDrv;
                MODE_PCM: src = pcmDrv;
                MODE_LB:  src = lbDrv;
            endcase

            stN.busOut = src.busOut;
            stN.busOe = src.busOe;

            if (ownNxt) begin
                stN.ideOut = ideDrv.out;
                stN.ideOe = ideDrv.oe;
            end else begin
                stN.ideOut = src.ideOut;
                stN.ideOe = src.ideOe;
            end

            unique case (stR.mode)
                MODE_ISA: begin
                    stN.busOe[P_LBA22 +: W_LBA_HI] = '0;
                    stN.busOe[P_LBSEL4 +: W_LBSEL_HI] = '0;
                    stN.isa_bus_output_enable = ownNxt;
                    // 24 MHz clock on its pad
                    stN.clkPass = 1'b1;
                    stN.busOe[P_CLK24] = 1'b1;
                end
                MODE_PCM: begin
                    if (!ownNxt) begin
                        stN.ideOut[P_DA2] = 1'b0;
                        stN.ideOe[P_DA2] = 1'b1;
                        stN.ideOe[P_DD_HIZ +: W_DD_HIZ] = '0;
                    end
                    stN.busOut[P_RTC_ADDR] = 1'b0;
                    stN.busOe[P_RTC_ADDR] = 1'b1;
                    stN.clkPass = 1'b1;
                    stN.busOe[P_CLK24] = 1'b1;
                    stN.busOe[P_IO16] = 1'b0;
                    stN.busOe[P_MASTER] = 1'b0;
                    stN.busOut[P_MEM16] = 1'b0;
                    stN.busOe[P_MEM16] = 1'b1;
                    stN.busOut[P_DMA_ACK +: W_DMA_ACK] = DMA_ACK_PCM;
                    stN.busOe[P_DMA_ACK +: W_DMA_ACK] = '1;
                    stN.busOut[P_TCOUNT] = 1'b0;
                    stN.busOe[P_TCOUNT] = 1'b1;
                    // memory strobes and latch have no card use
                    stN.busOut[P_MEMR] = 1'b0;
                    stN.busOut[P_ALE] = 1'b0;
                    stN.busOut[P_MEMW] = 1'b0;
                    stN.busOe[P_MEMR] = 1'b1;
                    stN.busOe[P_ALE] = 1'b1;
                    stN.busOe[P_MEMW] = 1'b1;
                    // card wait pad is an input
                    stN.busOe[P_AEN] = 1'b0;
                    stN.busOe[P_LBA22] = 1'b0;
                    // detect and ready pads are inputs
                    stN.busOe[P_LBSEL4 +: W_CARD_IN] = '0;
                    stN.isa_bus_output_enable = ownNxt;
                end
                MODE_LB: begin
                    // data ready pad is an input
                    stN.busOe[P_SA3] = 1'b0;
                    stN.isa_bus_output_enable = src.aux;
                    // flash select 1 from local bus
                    stN.clkPass = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        stR <= stN;
    end

    // 24 MHz passes unregistered; sampling it at 125 MHz would jitter
    always_comb begin
        padBusOut = stR.busOut;
        if (stR.clkPass) begin
            padBusOut[P_CLK24] = devClk24;
        end
    end

    assign padBusOe = stR.busOe;
    assign padIdeOut = stR.ideOut;
    assign padIdeOe = stR.ideOe;
    assign padIsaOe = stR.isa_bus_output_enable;
    assign activeMode = stR.mode;

    // grants follow the arbiter; pads switch on the same edge
    assign ideGrant = (stR.mode == MODE_LB) || (stR.arb == ARB_IDE);
    assign busGrant = (stR.mode == MODE_LB) || (stR.arb == ARB_BUS);

    // ready pad to its current user
    assign ideReady = stR.ideOwn ? padRdyIn : 1'b1;
    assign isaChRdy = (stR.mode == MODE_ISA) && !stR.ideOwn ?
                      padRdyIn : 1'b1;
    // data ready taken from low address pad
    assign lbDataReady = (stR.mode == MODE_LB) & padBusIn[P_SA3];

    ipm_clk_gen u_clk_gen (
        .clk            (clk),
        .rst_n          (rst_n),
        .pciDiv3        (stR.pciDiv3),
        .memSync        (stR.memSync),
        .memAsyncClk    (memAsyncClk),
        .isaBusClock    (isaBusClock),
        .pciClockOut    (pciClockOut),
        .memoryClockOut (memoryClockOut)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_ide_wanted;
        ideReq && !busBusy && (stR.arb == ARB_BUS);
    endsequence

    a_mode_static: assert property (
        $past(rst_n) |-> $stable(activeMode))
        else $error("bus mode changed outside reset");

    a_ide_grant_soon: assert property (
        ((activeMode != MODE_LB) and s_ide_wanted) |=> ideGrant)
        else $error("ide not granted after idle request");

    a_switch_idle: assert property (
        busGrant && busBusy && (activeMode != MODE_LB) |=> busGrant)
        else $error("ownership switched during bus cycle");

    a_isa_bus_output_enable_phase: assert property (
        $past(rst_n) && (activeMode != MODE_LB) |-> (padIsaOe == ideGrant))
        else $error("enable pad disagrees with ide phase");

    a_pcm_addr_zero: assert property (
        $past(rst_n) && (activeMode == MODE_PCM) && busGrant
            |-> !padIdeOut[P_DA2] && padIdeOe[P_DA2])
        else $error("address bit 2 not held zero for cards");

    a_pcm_data_float: assert property (
        (activeMode == MODE_PCM) && busGrant
            |-> (padIdeOe[P_DD_HIZ +: W_DD_HIZ] == '0))
        else $error("data 14:12 driven for cards");

    a_pcm_ack_code: assert property (
        (activeMode == MODE_PCM) ##1 (activeMode == MODE_PCM)
            |-> (padBusOut[P_DMA_ACK +: W_DMA_ACK] == DMA_ACK_PCM))
        else $error("acknowledge code not four for cards");

    a_isa_high_float: assert property (
        (activeMode == MODE_ISA) ##1 (activeMode == MODE_ISA)
            |-> (padBusOe[P_LBA22 +: W_LBA_HI] == '0))
        else $error("high address pads driven on isa");

    a_lb_ready_route: assert property (
        (activeMode == MODE_LB) |-> (lbDataReady == padBusIn[P_SA3])
            && !padBusOe[P_SA3])
        else $error("local bus ready not routed from pad");

    a_isa_rdy_route: assert property (
        (activeMode == MODE_PCM) |-> isaChRdy)
        else $error("channel ready active for cards");

endmodule

// ---- src/ipm_pkg.sv ----
// shared constants, pad layout and carrier types of the shared-pad mux
// assumes a single 125 MHz clock and board straps that hold still in use
package ipm_pkg;

    // strap-selected bus that owns the shared pads, one-hot
    typedef enum logic [2:0] {
        MODE_ISA = 3'b001,
        MODE_PCM = 3'b010,
        MODE_LB  = 3'b100
    } ipm_mode_type;

    // owner of the ide-shared pad group, one-hot
    typedef enum logic [1:0] {
        ARB_BUS = 2'b01,
        ARB_IDE = 2'b10
    } ipm_arb_type;

    // strap codes on strapMode
    localparam logic [1:0] STRAP_ISA = 2'h0;
    localparam logic [1:0] STRAP_PCM = 2'h1;
    localparam logic [1:0] STRAP_LB  = 2'h2;

    // pad group widths
    localparam int W_IDE = 23;
    localparam int W_BUS = 55;

    // ide-shared group: address, chip selects, data
    localparam int P_DA_LO   = 0;  // 2 pads
    localparam int P_DA2     = 2;
    localparam int P_CS      = 3;  // 4 pads: primary 1,3 then secondary 1,3
    localparam int P_DD      = 7;  // 16 pads
    localparam int P_DD_HIZ  = 19; // data bits 14:12, 3 pads
    localparam int W_DD_HIZ  = 3;
    localparam int P_DD15    = 22;

    // bus-only group, one column per pad
    localparam int P_SD       = 0;  // 16 pads
    localparam int P_RTC_ADDR = 16;
    localparam int P_CLK24    = 17;
    localparam int P_SA3      = 18;
    localparam int P_SA_LO    = 19; // 3 pads
    localparam int P_SMEMW    = 22;
    localparam int P_IO16     = 23;
    localparam int P_MASTER   = 24;
    localparam int P_MEM16    = 25;
    localparam int P_DMA_ACK  = 26; // 3 pads
    localparam int W_DMA_ACK  = 3;
    localparam int P_TCOUNT   = 29;
    localparam int P_SA4      = 30; // 4 pads
    localparam int P_ZWS      = 34;
    localparam int P_GPIO_SEL = 35;
    localparam int P_CHK      = 36;
    localparam int P_REFRESH  = 37;
    localparam int P_IOW      = 38;
    localparam int P_IOR      = 39;
    localparam int P_MEMR     = 40;
    localparam int P_ALE      = 41;
    localparam int P_AEN      = 42;
    localparam int P_BHE      = 43;
    localparam int P_MEMW     = 44;
    localparam int P_SMEMR    = 45;
    localparam int P_DMA_REQ  = 46; // 2 pads
    localparam int P_LBA22    = 48;
    localparam int W_LBA_HI   = 3;  // address 24:22
    localparam int P_LBSEL4   = 51; // selects 7:4, 4 pads
    localparam int W_LBSEL_HI = 4;
    localparam int W_CARD_IN  = 3;  // card detect pair and ready are inputs

    // fixed pad values
    localparam logic [2:0] DMA_ACK_PCM = 3'h4;
    localparam logic       RST_ISA_BUS_OUTPUT_ENABLE   = 1'b1;

    // clock generation
    localparam int CLK_HZ     = 125_000_000;
    localparam int ISA_BUS_CLOCK_HZ = 7_000_000;
    localparam int ISA_HALF   = (CLK_HZ + ISA_BUS_CLOCK_HZ) / (2 * ISA_BUS_CLOCK_HZ);
    localparam logic [3:0] ISA_HALF_LAST = 4'(ISA_HALF - 1);
    localparam logic [1:0] PCI_DIV2_LAST = 2'h1;
    localparam logic [1:0] PCI_DIV3_LAST = 2'h2;

    // what one controller wants on the pads
    typedef struct packed {
        logic [W_IDE-1:0] ideOut;
        logic [W_IDE-1:0] ideOe;
        logic [W_BUS-1:0] busOut;
        logic [W_BUS-1:0] busOe;
        logic             aux;    // local bus: select bit 3 value
    } ipm_src_drive_type;

    // what the ide controller wants on its group
    typedef struct packed {
        logic [W_IDE-1:0] out;
        logic [W_IDE-1:0] oe;
    } ipm_ide_drive_type;

endpackage

// ---- verification/ipm_pad_partner.sv ----
// far-side pad model: cards, local-bus devices and drives on the pads
// assumes registered pad outputs; the bench sets the device ready level
`timescale 1ns/1ps
module ipm_pad_partner
    import ipm_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rdyLevel,
    input  wire logic [W_BUS-1:0] padBusOut,
    input  wire logic [W_BUS-1:0] padBusOe,
    input  wire logic [W_IDE-1:0] padIdeOut,
    input  wire logic             padIsaOe,
    output logic                  padRdyIn,
    output logic [W_BUS-1:0]      padBusIn,
    output logic [3:0]            ideCsN
);
    logic [W_BUS-1:0] floatPat = '0;

    // released pads flip every cycle so a stale value cannot pass
    always_ff @(posedge clk) begin
        floatPat <= ~floatPat;
    end

    // wire level: driven pads win, the data-ready pad follows the device
    always_comb begin
        padBusIn = (padBusOut & padBusOe) | (floatPat & ~padBusOe);
        if (!padBusOe[P_SA3]) begin
            padBusIn[P_SA3] = rdyLevel;
        end
    end

    // a slow device holds ready low as long as the bench asks
    assign padRdyIn = rdyLevel;

    // board chip select gate
    // drives see their selects only in the ide phase, active low
    assign ideCsN = ~(padIdeOut[P_CS +: 4] & {4{padIsaOe}});
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the shared-pad mux in all three strap modes
// assumes one 125 MHz clock and the pad model on the far side
`timescale 1ns/1ps
module tb
    import ipm_pkg::*;
;
    logic              clk;
    logic              rst_n;
    logic [1:0]        strapMode;
    logic              strapPciDiv3;
    logic              strapMemSync;
    logic              devClk24;
    logic              memAsyncClk;
    ipm_ide_drive_type ideDrv;
    ipm_src_drive_type isaDrv;
    ipm_src_drive_type pcmDrv;
    ipm_src_drive_type lbDrv;
    logic              ideReq;
    logic              ideBusy;
    logic              busReq;
    logic              busBusy;
    logic              rdyLevel;
    logic              padRdyIn;
    logic [W_BUS-1:0]  padBusIn;
    logic              ideGrant;
    logic              busGrant;
    logic [W_IDE-1:0]  padIdeOut;
    logic [W_IDE-1:0]  padIdeOe;
    logic [W_BUS-1:0]  padBusOut;
    logic [W_BUS-1:0]  padBusOe;
    logic              padIsaOe;
    logic              ideReady;
    logic              isaChRdy;
    logic              lbDataReady;
    ipm_mode_type      activeMode;
    logic              isaBusClock;
    logic              pciClockOut;
    logic              memoryClockOut;
    logic [3:0]        ideCsN;
    int                n_fail = 0;
    int                checks = 0;

    ipm_pin_mux ipm_pin_mux_i (
        .clk(clk), .rst_n(rst_n), .strapMode(strapMode),
        .strapPciDiv3(strapPciDiv3), .strapMemSync(strapMemSync),
        .devClk24(devClk24), .memAsyncClk(memAsyncClk), .ideDrv(ideDrv),
        .isaDrv(isaDrv), .pcmDrv(pcmDrv), .lbDrv(lbDrv), .ideReq(ideReq),
        .ideBusy(ideBusy), .busReq(busReq), .busBusy(busBusy),
        .padRdyIn(padRdyIn), .padBusIn(padBusIn), .ideGrant(ideGrant),
        .busGrant(busGrant), .padIdeOut(padIdeOut), .padIdeOe(padIdeOe),
        .padBusOut(padBusOut), .padBusOe(padBusOe), .padIsaOe(padIsaOe),
        .ideReady(ideReady), .isaChRdy(isaChRdy),
        .lbDataReady(lbDataReady), .activeMode(activeMode),
        .isaBusClock(isaBusClock), .pciClockOut(pciClockOut),
        .memoryClockOut(memoryClockOut)
    );

    ipm_pad_partner ipm_pad_partner_i (
        .clk(clk), .rdyLevel(rdyLevel), .padBusOut(padBusOut),
        .padBusOe(padBusOe), .padIdeOut(padIdeOut), .padIsaOe(padIsaOe),
        .padRdyIn(padRdyIn), .padBusIn(padBusIn), .ideCsN(ideCsN)
    );

    // host clock, then pass-through clocks off the sampling instants
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        devClk24 = 1'b0;
        forever #20.8 devClk24 = ~devClk24;
    end
    initial begin
        memAsyncClk = 1'b0;
        forever #7.6 memAsyncClk = ~memAsyncClk;
    end

    // inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic do_reset(input logic [1:0] m, input logic d3,
                            input logic ms);
        rst_n = 1'b0;
        strapMode = m;
        strapPciDiv3 = d3;
        strapMemSync = ms;
        tick(3);
        chk("rstIsaOe", RST_ISA_BUS_OUTPUT_ENABLE, padIsaOe);
        chk("rstBusClk", 0, isaBusClock);
        chk("rstOe", 0, {padBusOe, 1'b0} | padIdeOe);
        rst_n = 1'b1;
        tick(1);
    endtask

    // length of the next run of one level on a generated clock, or the rest of the current one if already at that level
    task automatic runlen(input int sel, input logic lvl, output int n);
        int i;
        i = 0;
        while ((sel ? pciClockOut : isaBusClock) !== lvl && i < 100) begin
            tick(1);
            i++;
        end
        n = 0;
        while ((sel ? pciClockOut : isaBusClock) === lvl && n < 100) begin
            tick(1);
            n++;
        end
    endtask

    task automatic test_isa();
        do_reset(STRAP_ISA, 1'b0, 1'b0);
        rdyLevel = 1'b0;
        tick(1);
        chk("mode", MODE_ISA, activeMode);
        chk("busOe", 0, padIsaOe);
        chk("ideGrp", isaDrv.ideOut, padIdeOut);
        chk("sd", isaDrv.busOut[15:0], padBusOut[15:0]);
        chk("floatOe", 0, padBusOe[P_LBA22 +: 7]);
        chk("chRdy", 0, isaChRdy);
        chk("csIdle", 4'hf, ideCsN);
        busBusy = 1'b1;
        ideReq = 1'b1;
        tick(3);
        chk("holdBus", 0, ideGrant);
        busBusy = 1'b0;
        tick(1);
        chk("ideOwn", 1, ideGrant);
        chk("ideOe", 1, padIsaOe);
        chk("idePads", ideDrv.out, padIdeOut);
        chk("ideRdy", 0, ideReady);
        chk("csIde", {~ideDrv.out[P_CS +: 4]}, ideCsN);
        ideBusy = 1'b1;
        busReq = 1'b1;
        tick(3);
        chk("holdIde", 0, busGrant);
        ideBusy = 1'b0;
        ideReq = 1'b0;
        tick(1);
        chk("busBack", 1, busGrant);
        busReq = 1'b0;
        rdyLevel = 1'b1;
        $display("test isa done");
    endtask

    task automatic test_pcm();
        do_reset(STRAP_PCM, 1'b0, 1'b0);
        strapMode = STRAP_LB;
        rdyLevel = 1'b0;
        tick(2);
        chk("mode", MODE_PCM, activeMode);
        chk("da", 3'h3, padIdeOut[2:0]);
        chk("dd", 13'h1fff,
            {padIdeOut[P_DD15], padIdeOut[P_DD +: 12]});
        chk("ddHiz", 0, padIdeOe[P_DD_HIZ +: W_DD_HIZ]);
        chk("dack", DMA_ACK_PCM, padBusOut[P_DMA_ACK +: 3]);
        chk("rtc_addr_strobe", 0, padBusOut[P_RTC_ADDR]);
        chk("m16Tc", 0, {padBusOut[P_MEM16], padBusOut[P_TCOUNT]});
        chk("clk24", devClk24, padBusOut[P_CLK24]);
        chk("a22Oe", 0, padBusOe[P_LBA22]);
        chk("chRdy", 1, isaChRdy);
        rdyLevel = 1'b1;
        $display("test pcm done");
    endtask

    task automatic test_lb();
        do_reset(STRAP_LB, 1'b0, 1'b0);
        tick(1);
        chk("mode", MODE_LB, activeMode);
        chk("grants", 2'h3, {ideGrant, busGrant});
        chk("idePads", ideDrv.out, padIdeOut);
        chk("lbPads", {lbDrv.busOut[W_BUS-1:P_SA_LO],
            lbDrv.busOut[P_SA3-1:0]}, {padBusOut[W_BUS-1:P_SA_LO],
            padBusOut[P_SA3-1:0]});
        chk("rdyOe", 0, padBusOe[P_SA3]);
        for (int i = 0; i < 2; i++) begin
            lbDrv.aux = i[0];
            rdyLevel = i[0];
            tick(1);
            chk("sel3", i[0], padIsaOe);
            chk("lbRdy", i[0], lbDataReady);
        end
        $display("test lb done");
    endtask

    task automatic test_clk(input logic d3, input logic ms);
        int n;
        do_reset(STRAP_ISA, d3, ms);
        for (int s = 0; s < 2; s++) begin
            runlen(s, 1'b1, n);
            runlen(s, 1'b0, n);
            chk("lowLen", s ? 1 + d3 : ISA_HALF, n);
            runlen(s, 1'b1, n);
            chk("highLen", s ? 1 : ISA_HALF, n);
        end
        repeat (4) begin
            #2;
            chk("memClk", ms ? clk : memAsyncClk, memoryClockOut);
        end
        $display("test clk done");
    endtask

    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog: the tests need a few hundred cycles at most
    initial begin
        #20000;
        n_fail++;
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        strapMode = STRAP_ISA;
        strapPciDiv3 = 1'b0;
        strapMemSync = 1'b0;
        ideDrv = '{out: 23'h5a5a5, oe: '1};
        isaDrv = '{ideOut: 23'h2c3d1, ideOe: '1,
                   busOut: 55'h1234_5678_9abc, busOe: '1, aux: 1'b0};
        pcmDrv = '1;
        lbDrv = '{ideOut: '0, ideOe: '0,
                  busOut: 55'h6d5c_4b3a_2918, busOe: '1, aux: 1'b0};
        ideReq = 1'b0;
        ideBusy = 1'b0;
        busReq = 1'b0;
        busBusy = 1'b0;
        rdyLevel = 1'b1;
        test_isa();
        test_pcm();
        test_lb();
        test_clk(1'b0, 1'b0);
        test_clk(1'b1, 1'b1);
        test_done();
    end
endmodule
